//--- mcr_regs.sv
// module: calibration register bank on an axi4-lite slave, with trim datapath
// How it works
// - writable 8-bit amplifier gain select register
// - per-phase 12-bit voltage rms trim
// - per-phase 12-bit current rms trim
// - current trim also scales watt and var
// - per-phase 12-bit active power trim
// - per-phase 12-bit reactive power trim
// - per-phase 12-bit apparent power trim
// - per-phase 12-bit voltage rms offset
// - phase a, b current rms offset
// - 8-bit compensation mode register kept
`timescale 1ns/1ps

module mcr_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [mcr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [mcr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire mcr_pkg::mcr_res_t raw_res [mcr_pkg::NPH],
  output mcr_pkg::mcr_res_t cal_res [mcr_pkg::NPH],
  output logic [mcr_pkg::GAIN_W-1:0] amp_gain_sel,
  output logic [mcr_pkg::MODE_W-1:0] comp_mode
);
  import mcr_pkg::*;

  // ==========================================================
  // helpers

  // true for an index inside the trim and offset run
  function automatic logic is_trim(input logic [IDX_W-1:0] idx);
    is_trim = (idx >= IDX_VRMS_TRIM_A) && (idx <= IDX_IRMS_OFS_B);
  endfunction : is_trim

  // true for any index the bank answers
  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = is_trim(idx) || (idx == IDX_AMP_SEL) || (idx == IDX_COMP_MODE);
  endfunction : is_mapped

  // slot number of a trim register inside the storage array
  function automatic logic [4:0] slot_of(input logic [IDX_W-1:0] idx);
    logic [IDX_W-1:0] d;
    d = idx - IDX_VRMS_TRIM_A;
    slot_of = d[4:0];
  endfunction : slot_of

  // byte-lane merge into a 12-bit register
  function automatic logic [TRIM_W-1:0] merge12(input logic [TRIM_W-1:0] old,
                                                input logic [31:0] d,
                                                input logic [3:0] be);
    merge12 = old;
    if (be[0]) begin
      merge12[7:0] = d[7:0];
    end
    if (be[1]) begin
      merge12[11:8] = d[11:8];
    end
  endfunction : merge12

  // clip a two-bit-wider sum back into the result range
  function automatic mcr_val_t sat(input logic signed [RES_W+1:0] s);
    logic signed [RES_W+1:0] hi;
    logic signed [RES_W+1:0] lo;
    hi = {{2{1'b0}}, 1'b0, {(RES_W-1){1'b1}}};
    lo = {{2{1'b1}}, 1'b1, {(RES_W-1){1'b0}}};
    if (s > hi) begin
      sat = hi[RES_W-1:0];
    end else if (s < lo) begin
      sat = lo[RES_W-1:0];
    end else begin
      sat = s[RES_W-1:0];
    end
  endfunction : sat

  // multiply by one plus trim over 4096, trim signed
  function automatic mcr_val_t scale(input mcr_val_t v, input logic [TRIM_W-1:0] t);
    logic signed [RES_W+TRIM_W-1:0] prod;
    logic signed [RES_W+TRIM_W-1:0] step;
    logic signed [RES_W+1:0] sum;
    prod = v * $signed(t);
    // shift on its own so it stays arithmetic; a concat operand would turn it logical
    step = prod >>> TRIM_SH;
    sum = $signed({{2{v[RES_W-1]}}, v}) + $signed(step[RES_W+1:0]);
    scale = sat(sum);
  endfunction : scale

  // add a signed 12-bit offset with clipping
  function automatic mcr_val_t add_ofs(input mcr_val_t v, input logic [TRIM_W-1:0] o);
    logic signed [RES_W+1:0] sum;
    sum = {{2{v[RES_W-1]}}, v} + {{(RES_W+2-TRIM_W){o[TRIM_W-1]}}, o};
    add_ofs = sat(sum);
  endfunction : add_ofs

  // ==========================================================
  // storage
  logic [TRIM_W-1:0] trim_ff [NTRIM]; // trims and offsets, slot order
  logic [GAIN_W-1:0] gain_ff; // amplifier select
  logic [MODE_W-1:0] mode_ff; // compensation mode
  logic bvalid_ff; // write answer pending
  logic [1:0] bresp_ff; // write answer code
  logic rvalid_ff; // read answer pending
  logic [1:0] rresp_ff; // read answer code
  logic [31:0] rdata_ff; // read data held until taken
  mcr_res_t cal_ff [NPH]; // corrected results

  // ==========================================================
  // write channel decode
  wire logic wr_go = awvalid && wvalid && !bvalid_ff; // both halves taken together
  wire logic [IDX_W-1:0] wr_idx = awaddr[IDX_W+1:2];
  wire logic wr_hit = is_mapped(wr_idx);
  wire logic wr_trim = wr_go && is_trim(wr_idx);
  wire logic [4:0] wr_slot = slot_of(wr_idx);
  wire logic wr_gain = wr_go && (wr_idx == IDX_AMP_SEL) && wstrb[0];
  wire logic wr_mode = wr_go && (wr_idx == IDX_COMP_MODE) && wstrb[0];

  // ready only when both address and data stand, one write at a time
  assign awready = wr_go;
  assign wready = wr_go;

  // ==========================================================
  // read channel decode
  wire logic rd_go = arvalid && !rvalid_ff;
  wire logic [IDX_W-1:0] rd_idx = araddr[IDX_W+1:2];
  wire logic rd_hit = is_mapped(rd_idx);
  wire logic [4:0] rd_slot = slot_of(rd_idx);
  wire logic [31:0] rd_trim = {{(32-TRIM_W){1'b0}}, trim_ff[rd_slot]};
  wire logic [31:0] rd_gain = {{(32-GAIN_W){1'b0}}, gain_ff};
  wire logic [31:0] rd_mode = {{(32-MODE_W){1'b0}}, mode_ff};
  // unmapped and reserved reads return zero
  wire logic [31:0] rd_val = is_trim(rd_idx) ? rd_trim :
                             (rd_idx == IDX_AMP_SEL) ? rd_gain :
                             (rd_idx == IDX_COMP_MODE) ? rd_mode : 32'h0000_0000;

  assign arready = !rvalid_ff;

  // ==========================================================
  // trim and offset registers
  // slots cleared at reset so nothing is trimmed before software acts
  generate
    for (genvar s = 0; s < NTRIM; s++) begin : g_trim
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          trim_ff[s] <= TRIM_RST;
        end else if (wr_trim && (wr_slot == 5'(s))) begin
          trim_ff[s] <= merge12(trim_ff[s], wdata, wstrb);
        end
      end
    end
  endgenerate

  // amplifier select, steers the input channels outside
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_ff <= AMP_SEL_RST;
    end else if (wr_gain) begin
      gain_ff <= wdata[GAIN_W-1:0];
    end
  end

  // compensation mode, consumed by the energy formula logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= COMP_MODE_RST;
    end else if (wr_mode) begin
      mode_ff <= wdata[MODE_W-1:0];
    end
  end

  assign amp_gain_sel = gain_ff;
  assign comp_mode = mode_ff;

  // ==========================================================
  // write answer
  // response rises on the edge that takes the write, held until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // ==========================================================
  // read answer
  // data is latched so it cannot move while the master stalls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= rd_val;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;

  // ==========================================================
  // correction datapath, one register stage per phase
  // trims come straight from the bank, so a write acts on the next edge
  generate
    for (genvar p = 0; p < NPH; p++) begin : g_ph
      localparam int SV = int'(IDX_VRMS_TRIM_A - IDX_VRMS_TRIM_A) + p;
      localparam int SI = int'(IDX_CUR_TRIM_A - IDX_VRMS_TRIM_A) + p;
      localparam int SW = int'(IDX_ACT_TRIM_A - IDX_VRMS_TRIM_A) + p;
      localparam int SR = int'(IDX_REA_TRIM_A - IDX_VRMS_TRIM_A) + p;
      localparam int SA = int'(IDX_APP_TRIM_A - IDX_VRMS_TRIM_A) + p;
      localparam int SO = int'(IDX_VRMS_OFS_A - IDX_VRMS_TRIM_A) + p;
      localparam int SC = int'(IDX_IRMS_OFS_A - IDX_VRMS_TRIM_A) + p;
      // phase c has no current rms offset in this bank
      wire logic [TRIM_W-1:0] irms_ofs = (SC < NTRIM) ? trim_ff[(SC < NTRIM) ? SC : 0] : TRIM_RST;
      wire mcr_val_t i_watt = scale(raw_res[p].watt, trim_ff[SI]);
      wire mcr_val_t i_var = scale(raw_res[p].var_p, trim_ff[SI]);
      wire mcr_val_t nxt_vrms = add_ofs(scale(raw_res[p].vrms, trim_ff[SV]), trim_ff[SO]);
      wire mcr_val_t nxt_irms = add_ofs(scale(raw_res[p].irms, trim_ff[SI]), irms_ofs);
      wire mcr_val_t nxt_watt = scale(i_watt, trim_ff[SW]);
      wire mcr_val_t nxt_var = scale(i_var, trim_ff[SR]);
      wire mcr_val_t nxt_va = scale(raw_res[p].va, trim_ff[SA]);

      // register the corrected set, trim arithmetic in scale()
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cal_ff[p] <= '0;
        end else begin
          cal_ff[p] <= '{vrms: nxt_vrms, irms: nxt_irms, watt: nxt_watt, var_p: nxt_var, va: nxt_va};
        end
      end

      assign cal_res[p] = cal_ff[p];
    end
  endgenerate

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // trim slots 0, 9 and NTRIM-1, select and mode hold their reset values at the first edge out of reset
  reset_clear_a: assert property ($rose(aresetn) |-> (trim_ff[0] == TRIM_RST) && (trim_ff[NTRIM-1] == TRIM_RST) &&
                                  (trim_ff[9] == TRIM_RST) && (gain_ff == AMP_SEL_RST) && (mode_ff == COMP_MODE_RST))
    else $error("bank not clear after reset");

  gain_write_a: assert property (wr_gain |=> amp_gain_sel == $past(wdata[GAIN_W-1:0]))
    else $error("amplifier select not stored");

  mode_write_a: assert property (wr_mode |=> comp_mode == $past(wdata[MODE_W-1:0]))
    else $error("compensation mode not stored");

  vrms_unity_a: assert property (trim_ff[0] == '0 && trim_ff[15] == '0 ##1 trim_ff[0] == '0
                                 |-> cal_res[0].vrms == $past(raw_res[0].vrms))
    else $error("vrms altered with zero trim");

  irms_offset_a: assert property (trim_ff[3] == '0
                                  |=> cal_res[0].irms == add_ofs($past(raw_res[0].irms), $past(trim_ff[18])))
    else $error("irms offset not applied");

  watt_unity_a: assert property (trim_ff[3] == '0 && trim_ff[6] == '0
                                 |=> cal_res[0].watt == $past(raw_res[0].watt))
    else $error("watt altered with zero trims");

  var_curtrim_a: assert property (trim_ff[9] == '0
                                  |=> cal_res[0].var_p == scale($past(raw_res[0].var_p), $past(trim_ff[3])))
    else $error("current trim missing from var");

  va_unity_a: assert property (trim_ff[12] == '0 |=> cal_res[0].va == $past(raw_res[0].va))
    else $error("va altered with zero trim");

  react_scale_a: assert property (trim_ff[4] == '0
                                  |=> cal_res[1].var_p == scale($past(raw_res[1].var_p), $past(trim_ff[10])))
    else $error("reactive trim not applied");

  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");

  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer moved while stalled");

endmodule : mcr_regs

//--- mcr_pkg.sv
// package: register map, widths and result carrier for the calibration bank
package mcr_pkg;

  // ==========================================================
  // widths
  localparam int RES_W = 24; // width of one measurement result
  localparam int TRIM_W = 12; // width of every trim and offset
  localparam int GAIN_W = 8; // width of the amplifier select
  localparam int MODE_W = 8; // width of the compensation mode
  localparam int IDX_W = 6; // register index width
  localparam int ADDR_W = 8; // byte address width on the bus
  localparam int TRIM_SH = 12; // one step is 1/4096 of full value
  localparam int NPH = 3; // phases

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_COMP_MODE = 6'h16;
  localparam logic [IDX_W-1:0] IDX_AMP_SEL = 6'h23;
  localparam logic [IDX_W-1:0] IDX_VRMS_TRIM_A = 6'h24;
  localparam logic [IDX_W-1:0] IDX_VRMS_TRIM_B = 6'h25;
  localparam logic [IDX_W-1:0] IDX_VRMS_TRIM_C = 6'h26;
  localparam logic [IDX_W-1:0] IDX_CUR_TRIM_A = 6'h27;
  localparam logic [IDX_W-1:0] IDX_CUR_TRIM_B = 6'h28;
  localparam logic [IDX_W-1:0] IDX_CUR_TRIM_C = 6'h29;
  localparam logic [IDX_W-1:0] IDX_ACT_TRIM_A = 6'h2a;
  localparam logic [IDX_W-1:0] IDX_ACT_TRIM_B = 6'h2b;
  localparam logic [IDX_W-1:0] IDX_ACT_TRIM_C = 6'h2c;
  localparam logic [IDX_W-1:0] IDX_REA_TRIM_A = 6'h2d;
  localparam logic [IDX_W-1:0] IDX_REA_TRIM_B = 6'h2e;
  localparam logic [IDX_W-1:0] IDX_REA_TRIM_C = 6'h2f;
  localparam logic [IDX_W-1:0] IDX_APP_TRIM_A = 6'h30;
  localparam logic [IDX_W-1:0] IDX_APP_TRIM_B = 6'h31;
  localparam logic [IDX_W-1:0] IDX_APP_TRIM_C = 6'h32;
  localparam logic [IDX_W-1:0] IDX_VRMS_OFS_A = 6'h33;
  localparam logic [IDX_W-1:0] IDX_VRMS_OFS_B = 6'h34;
  localparam logic [IDX_W-1:0] IDX_VRMS_OFS_C = 6'h35;
  localparam logic [IDX_W-1:0] IDX_IRMS_OFS_A = 6'h36;
  localparam logic [IDX_W-1:0] IDX_IRMS_OFS_B = 6'h37;
  localparam int NTRIM = 20; // slots from the first voltage trim on

  // ==========================================================
  // reset values
  localparam logic [TRIM_W-1:0] TRIM_RST = 12'h000;
  localparam logic [GAIN_W-1:0] AMP_SEL_RST = 8'h00;
  localparam logic [MODE_W-1:0] COMP_MODE_RST = 8'h1c;

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // one phase worth of results
  typedef logic signed [RES_W-1:0] mcr_val_t;
  typedef struct packed {
    mcr_val_t vrms;
    mcr_val_t irms;
    mcr_val_t watt;
    mcr_val_t var_p;
    mcr_val_t va;
  } mcr_res_t;

endpackage : mcr_pkg

//--- mcr_regs_tb_top.sv
// testbench: axi4-lite register checks and trim datapath checks for the calibration bank
`timescale 1ns/1ps

module mcr_regs_tb_top;
  import mcr_pkg::*;

  // ==========================================================
  // signals
  logic aclk; // 200 mhz
  logic aresetn; // active low
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  mcr_res_t raw_res [NPH];
  mcr_res_t cal_res [NPH];
  logic [GAIN_W-1:0] amp_gain_sel;
  logic [MODE_W-1:0] comp_mode;
  int n_fail = 0; // mismatches
  int checks = 0; // comparisons
  int cyc = 0; // cycle counter for the timeout
  logic [1:0] rsp;
  logic [31:0] rd;
  logic [31:0] wd;
  // phase a trims: indices and values for the datapath test
  logic [IDX_W-1:0] pa_idx [7] = '{6'h24, 6'h27, 6'h2a, 6'h2d, 6'h30, 6'h33, 6'h36};
  logic [11:0] pa_val [7] = '{12'h400, 12'h800, 12'h000, 12'h400, 12'hc00, 12'h010, 12'hfff};

  mcr_regs dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .raw_res(raw_res),
    .cal_res(cal_res), .amp_gain_sel(amp_gain_sel), .comp_mode(comp_mode)
  );

  // ==========================================================
  // clock and timeout
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // a hung handshake would otherwise stall the run forever
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      $display("Error %0t timeout", $time);
      end_sim();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // write: address and data offered together, held until taken
  task automatic axi_wr(input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // read: address held until taken, rready held until rvalid seen
  task automatic axi_rd(input logic [IDX_W-1:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // set every phase's raw results, then look one edge after they were sampled
  task automatic drive_raw(input int v);
    @(posedge aclk);
    for (int p = 0; p < NPH; p++) begin
      raw_res[p] <= '{vrms: 24'(v), irms: 24'(v), watt: 24'(v), var_p: 24'(v), va: 24'(v)};
    end
    repeat (2) @(posedge aclk);
    #1;
  endtask : drive_raw

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    for (int p = 0; p < NPH; p++) raw_res[p] = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values read back zero, mode register its own value
    for (int i = 'h23; i <= 'h37; i++) begin
      axi_rd(6'(i), rd, rsp);
      chk(rd, 32'h0, "reset read");
      chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "reset read resp");
    end
    axi_rd(IDX_COMP_MODE, rd, rsp);
    chk(rd, 32'h1c, "mode reset");
    chk({24'h0, amp_gain_sel}, 32'h0, "gain port reset");
    // with zero trims the results pass unchanged
    drive_raw(4000);
    chk({8'h0, cal_res[0].watt}, 32'd4000, "untrimmed watt");
    chk({8'h0, cal_res[1].va}, 32'd4000, "untrimmed phase b va");
    chk({8'h0, cal_res[2].irms}, 32'd4000, "untrimmed phase c irms");
    // select and every trim and offset register writable, width-limited on readback
    for (int i = 'h23; i <= 'h37; i++) begin
      wd = 32'hffff_f800 | i;
      axi_wr(6'(i), wd, 4'hf, rsp);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "write resp");
      axi_rd(6'(i), rd, rsp);
      chk(rd, (i == 'h23) ? {24'h0, wd[7:0]} : {20'h0, wd[11:0]}, "readback");
    end
    chk({24'h0, amp_gain_sel}, 32'h23, "gain port");
    // lane strobes: upper lane only, and a select write without lane zero
    axi_wr(IDX_CUR_TRIM_B, 32'h0000_0355, 4'h2, rsp);
    axi_rd(IDX_CUR_TRIM_B, rd, rsp);
    chk(rd, 32'h328, "upper lane only");
    axi_wr(IDX_AMP_SEL, 32'h0000_0077, 4'he, rsp);
    chk({24'h0, amp_gain_sel}, 32'h23, "masked select");
    axi_wr(IDX_COMP_MODE, 32'h03, 4'hf, rsp);
    chk({24'h0, comp_mode}, 32'h03, "mode port");
    // unmapped place: refused write and zero read
    axi_wr(6'h10, 32'h1234, 4'hf, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(6'h10, rd, rsp);
    chk(rd, 32'h0, "unmapped read data");
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    // phase a trims; formula select in bits 1:0 kept off mode zero
    axi_wr(IDX_COMP_MODE, 32'h1d, 4'hf, rsp);
    for (int k = 0; k < 7; k++) axi_wr(pa_idx[k], {20'h0, pa_val[k]}, 4'hf, rsp);
    drive_raw(4000);
    chk({8'h0, cal_res[0].vrms}, 32'd5016, "vrms trim plus offset");
    chk({8'h0, cal_res[0].irms}, 32'd1999, "irms trim plus offset");
    chk({8'h0, cal_res[0].watt}, 32'd2000, "watt via current trim");
    chk({8'h0, cal_res[0].var_p}, 32'd2500, "var trims chained");
    chk({8'h0, cal_res[0].va}, 32'd3000, "va trim negative");
    // watt trim alone, then clipping at full scale
    axi_wr(IDX_CUR_TRIM_A, 32'h0, 4'hf, rsp);
    axi_wr(IDX_ACT_TRIM_A, 32'h800, 4'hf, rsp);
    axi_wr(IDX_IRMS_OFS_A, 32'h7ff, 4'hf, rsp);
    drive_raw(4000);
    chk({8'h0, cal_res[0].watt}, 32'd2000, "watt trim");
    chk({8'h0, cal_res[0].irms}, 32'd6047, "irms offset");
    chk({8'h0, cal_res[0].vrms}, 32'd5016, "vrms steady");
    drive_raw('h7ff000);
    chk({8'h0, cal_res[0].vrms}, 32'h7fffff, "saturated vrms");
    end_sim();
  end

endmodule : mcr_regs_tb_top
